// ### hdl/cal_seq_pkg.sv
// package: constants and types for the calibration command sequencer
package cal_seq_pkg;

  // ----------------------------------------------------------------------
  // command codes and step numbers
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_CAL      = 4'h0;
  localparam logic [3:0] CMD_OPERATE  = 4'h1;
  localparam logic [3:0] CMD_SENSE    = 4'h2;
  localparam logic [3:0] CMD_STATUS   = 4'h3;
  localparam logic [3:0] CMD_DEFAULTS = 4'h4;
  localparam logic [3:0] CMD_HV_RANGE = 4'h5;

  localparam logic [5:0] STEP_ENTER    = 6'h00;
  localparam logic [5:0] STEP_HV_FIRST = 6'h1A;
  localparam logic [5:0] STEP_HV_LAST  = 6'h21;
  localparam logic [5:0] STEP_SRC_CAL  = 6'h3A;
  localparam logic [5:0] STEP_EXIT     = 6'h3B;

  // ----------------------------------------------------------------------
  // error status word bit positions and reset values
  // ----------------------------------------------------------------------
  localparam int ERR_NOT_ENTERED = 0;
  localparam int ERR_ILLEGAL_CMD = 1;
  localparam int ERR_BAD_STEP    = 2;
  localparam int ERR_HV_DISABLED = 3;
  localparam int ERR_NO_VALUE    = 4;
  localparam logic [7:0] ERR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // user settings held while calibrating
  // ----------------------------------------------------------------------
  localparam logic [15:0] CAL_SETTINGS = 16'h0001;
  localparam logic [15:0] USER_RESET   = 16'h0000;

  // step classification
  typedef enum logic [2:0] {
    KIND_ENTER   = 3'b000,
    KIND_SETUP   = 3'b001,
    KIND_MEASURE = 3'b010,
    KIND_SRC_CAL = 3'b011,
    KIND_EXIT    = 3'b100,
    KIND_COMMON  = 3'b101,
    KIND_BAD     = 3'b110
  } step_kind_t;

  // one terminated command from the bus controller
  typedef struct packed {
    logic [3:0]  code;
    logic [5:0]  step;
    logic        has_value;
    logic [23:0] value;
  } cmd_t;

  // calibration status word
  typedef struct packed {
    logic [5:0] step;
    logic       active;
    logic       unlocked;
    logic       calibrated;
  } cal_status_t;

endpackage

// ### hdl/calibration_command_sequencer.sv
// calibration command sequencer: steps, gating, settings save, commit
`timescale 1ns/1ps

module calibration_command_sequencer
  import cal_seq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_valid,
  input  wire cmd_t        cmd,
  input  wire logic        device_clear,
  input  wire logic        lock_unlocked,
  input  wire logic        bus_trigger,
  input  wire logic        panel_trigger,
  input  wire logic [15:0] user_settings,
  output logic [15:0]      active_settings,
  output logic             cal_active,
  output logic             trigger_armed,
  output logic             trigger_fire,
  output logic             pending_trigger,
  output logic             step_strobe,
  output logic [5:0]       step_number,
  output logic [23:0]      step_value,
  output logic             nvm_write,
  output logic             reading_done,
  output logic             reading_available,
  output logic             cmd_error,
  output cal_status_t      calibration_status_word,
  output logic [7:0]       error_status_word,
  output logic             high_voltage_range_enable
);

  // ----------------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------------

  // classify a step number into its kind
  function automatic step_kind_t classify(input logic [5:0] s);
    step_kind_t k;
    k = KIND_BAD;
    if (s == STEP_ENTER)
      k = KIND_ENTER;
    else if (s == 6'h01)
      k = KIND_COMMON;
    else if (s == STEP_SRC_CAL)
      k = KIND_SRC_CAL;
    else if (s == STEP_EXIT)
      k = KIND_EXIT;
    else if (s < STEP_SRC_CAL)
      k = s[0] ? KIND_MEASURE : KIND_SETUP;
    return k;
  endfunction

  logic        cal_active_reg;
  logic        hv_en_reg;
  logic [15:0] saved_reg;
  step_kind_t  kind;
  logic        is_cal;
  logic        allowed;
  logic        hv_step;
  logic        step_ok;
  logic        clear_all;

  // command acceptance terms
  always_comb
  begin
    kind    = classify(cmd.step);
    is_cal  = cmd.code == CMD_CAL;
    allowed = is_cal || cmd.code == CMD_OPERATE ||
              cmd.code == CMD_SENSE || cmd.code == CMD_STATUS;
    hv_step = cmd.step >= STEP_HV_FIRST && cmd.step <= STEP_HV_LAST;
    step_ok = 1'b0;
    if (cmd_valid && is_cal)
    begin
      if (kind == KIND_ENTER)
        step_ok = 1'b1;
      else if (!cal_active_reg || kind == KIND_BAD)
        step_ok = 1'b0;
      else if (hv_step && !hv_en_reg)
        step_ok = 1'b0;
      else if (kind == KIND_MEASURE && !cmd.has_value)
        step_ok = 1'b0;
      else
        step_ok = 1'b1;
    end
    clear_all = device_clear ||
                (cmd_valid && cmd.code == CMD_DEFAULTS && !cal_active_reg);
  end

  // ----------------------------------------------------------------------
  // step state
  // ----------------------------------------------------------------------

  logic [5:0] step_reg;
  logic       calibrated_reg;

  // power-up and clear go to step zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || clear_all)
    begin
      cal_active_reg <= 1'b0;
      step_reg       <= STEP_ENTER;
    end
    else if (step_ok)
    begin
      cal_active_reg <= kind != KIND_EXIT;
      step_reg       <= (kind == KIND_EXIT) ? STEP_ENTER : cmd.step;
    end
  end

  // calibrated flag set once the source step has run
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      calibrated_reg <= 1'b0;
    else if (step_ok && kind == KIND_SRC_CAL)
      calibrated_reg <= 1'b1;
  end

  // high-voltage range enable command
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || clear_all)
      hv_en_reg <= 1'b0;
    else if (cmd_valid && cmd.code == CMD_HV_RANGE && !cal_active_reg)
      hv_en_reg <= cmd.value[0];
  end

  // ----------------------------------------------------------------------
  // user settings save and restore
  // ----------------------------------------------------------------------

  logic [15:0] active_reg;

  // forced values on entry, saved copy kept
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      saved_reg  <= USER_RESET;
      active_reg <= USER_RESET;
    end
    else if (step_ok && kind == KIND_ENTER && !cal_active_reg)
    begin
      saved_reg  <= user_settings;
      active_reg <= CAL_SETTINGS;
    end
    else if (step_ok && kind == KIND_EXIT)
      active_reg <= saved_reg;
    else if (!cal_active_reg)
      active_reg <= user_settings;
  end

  // ----------------------------------------------------------------------
  // trigger handling
  // ----------------------------------------------------------------------

  logic armed_reg;
  logic pending_reg;
  logic fire_reg;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      armed_reg <= 1'b1;
    else if (cmd_valid && is_cal)
      armed_reg <= 1'b0;
    else if (!cal_active_reg && (bus_trigger || panel_trigger))
      armed_reg <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      fire_reg <= 1'b0;
    else
      fire_reg <= !cal_active_reg && armed_reg &&
                  (bus_trigger || panel_trigger) && !(cmd_valid && is_cal);
  end

  // panel trigger shows pending, cleared without sweep on exit
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || clear_all)
      pending_reg <= 1'b0;
    else if (cal_active_reg && panel_trigger)
      pending_reg <= 1'b1;
    else if (step_ok && kind == KIND_EXIT)
      pending_reg <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // step outputs and constant commit
  // ----------------------------------------------------------------------

  logic        strobe_reg;
  logic [23:0] value_reg;
  logic        nvm_reg;
  logic        done_reg;

  // step and value handed to analog section
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      strobe_reg <= 1'b0;
      value_reg  <= 24'h000000;
    end
    else
    begin
      strobe_reg <= step_ok;
      if (step_ok)
        value_reg <= cmd.has_value ? cmd.value : 24'h000000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      nvm_reg <= 1'b0;
    else
      nvm_reg <= step_ok && kind == KIND_EXIT && lock_unlocked;
  end

  // reading done after each step, sticky until next command
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || clear_all)
      done_reg <= 1'b0;
    else if (step_ok)
      done_reg <= 1'b1;
    else if (cmd_valid)
      done_reg <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // error status word
  // ----------------------------------------------------------------------

  logic [7:0] err_reg;
  logic [7:0] err_next;
  logic       err_pulse_reg;

  always_comb
  begin
    err_next = 8'h00;
    if (cmd_valid && is_cal && !step_ok)
    begin
      err_next[ERR_NOT_ENTERED] = !cal_active_reg;
      err_next[ERR_BAD_STEP]    = cal_active_reg && kind == KIND_BAD;
      err_next[ERR_HV_DISABLED] = cal_active_reg && hv_step && !hv_en_reg;
      err_next[ERR_NO_VALUE]    = cal_active_reg &&
                                  kind == KIND_MEASURE && !cmd.has_value;
    end
    if (cmd_valid && cal_active_reg && !allowed)
      err_next[ERR_ILLEGAL_CMD] = 1'b1;
  end

  // sticky word, cleared by a status read; new errors win over the clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      err_reg       <= ERR_RESET;
      err_pulse_reg <= 1'b0;
    end
    else
    begin
      if (cmd_valid && cmd.code == CMD_STATUS)
        err_reg <= err_next;
      else
        err_reg <= err_reg | err_next;
      err_pulse_reg <= |err_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  always_comb
  begin
    calibration_status_word.step       = step_reg;
    calibration_status_word.active     = cal_active_reg;
    calibration_status_word.unlocked   = lock_unlocked;
    calibration_status_word.calibrated = calibrated_reg;
  end

  assign active_settings           = active_reg;
  assign cal_active                = cal_active_reg;
  assign trigger_armed             = armed_reg;
  assign trigger_fire              = fire_reg;
  assign pending_trigger           = pending_reg;
  assign step_strobe               = strobe_reg;
  assign step_number               = step_reg;
  assign step_value                = value_reg;
  assign nvm_write                 = nvm_reg;
  assign reading_done              = done_reg;
  assign reading_available         = 1'b0; // no reading from cal steps
  assign cmd_error                 = err_pulse_reg;
  assign error_status_word         = err_reg;
  assign high_voltage_range_enable = hv_en_reg;

endmodule

// ### verification/cal_ctrl_model.sv
// bus controller model: issues single terminated commands
`timescale 1ns/1ps
module cal_ctrl_model
  import cal_seq_pkg::*;
(
  input  wire logic core_clk,
  output cmd_t      cmd,
  output logic      cmd_valid
);
  // bus idle at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // one whole command, step always given
  task automatic send(input logic [3:0] c, input logic [5:0] s,
                      input logic v, input logic [23:0] d);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd       = '{code: c, step: s, has_value: v, value: d};
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cmd       = ~cmd; // released bus shows the inverted last command as garbage
  endtask
endmodule

// ### verification/calibration_command_sequencer_checker.sv
// checker: port relations of the calibration command sequencer
`timescale 1ns/1ps
module calibration_command_sequencer_checker
  import cal_seq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        cmd_valid,
  input wire cmd_t        cmd,
  input wire logic        device_clear,
  input wire logic        lock_unlocked,
  input wire logic [15:0] active_settings,
  input wire logic        cal_active,
  input wire logic        trigger_armed,
  input wire logic        trigger_fire,
  input wire logic        step_strobe,
  input wire logic [5:0]  step_number,
  input wire logic        nvm_write,
  input wire logic        reading_done,
  input wire logic        reading_available,
  input wire logic        cmd_error,
  input wire cal_status_t calibration_status_word,
  input wire logic [7:0]  error_status_word,
  input wire logic        high_voltage_range_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------------
  // calibration command sequences
  // --------------------------------------------------------------------
  sequence s_cal;
    cmd_valid && cmd.code == CMD_CAL;
  endsequence
  sequence s_enter;
    cmd_valid && cmd.code == CMD_CAL && cmd.step == STEP_ENTER;
  endsequence
  sequence s_exit;
    cal_active && cmd_valid && cmd.code == CMD_CAL
      && cmd.step == STEP_EXIT;
  endsequence

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  a_step_needs_entry: assert property (s_cal ##0 (!cal_active
    && cmd.step inside {[1:59]}) |=> !step_strobe
    && error_status_word[ERR_NOT_ENTERED]) else $error("step taken early");
  a_entry_forces: assert property (s_enter |=> cal_active
    && step_strobe && active_settings == CAL_SETTINGS && !trigger_armed)
    else $error("entry state wrong");
  a_exit_commit: assert property (s_exit |=> !cal_active
    && step_number == STEP_ENTER && nvm_write == $past(lock_unlocked))
    else $error("exit state wrong");
  a_illegal_refused: assert property (cal_active && cmd_valid
    && cmd.code == CMD_DEFAULTS |=> cmd_error && $stable(step_number)
    && error_status_word[ERR_ILLEGAL_CMD]) else $error("illegal taken");
  a_no_fire_cal: assert property (cal_active |=> !trigger_fire)
    else $error("sweep during calibration");
  a_done_no_data: assert property (step_strobe |-> reading_done
    && !reading_available) else $error("reading done wrong");
  a_clear_step: assert property (device_clear && !cmd_valid
    |=> step_number == STEP_ENTER) else $error("clear kept step");
  a_status_word: assert property (calibration_status_word.step
    == step_number && calibration_status_word.active == cal_active
    && calibration_status_word.unlocked == lock_unlocked)
    else $error("status word wrong");
  a_hv_refused: assert property (s_cal ##0 (cal_active
    && cmd.step inside {[26:33]} && !high_voltage_range_enable)
    |=> !step_strobe && error_status_word[ERR_HV_DISABLED])
    else $error("high voltage step taken");
  a_calibrated_set: assert property (
    $rose(calibration_status_word.calibrated)
    |-> step_strobe && step_number == STEP_SRC_CAL)
    else $error("calibrated set early");
endmodule

bind calibration_command_sequencer calibration_command_sequencer_checker
  chk_i (.*);

// ### verification/calibration_command_sequencer_test.sv
// testbench: calibration command sequencer scenarios
`timescale 1ns/1ps
module calibration_command_sequencer_test
  import cal_seq_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cmd_valid;
  cmd_t        cmd;
  logic        device_clear = 1'b0;
  logic        lock_unlocked = 1'b0;
  logic        bus_trigger = 1'b0;
  logic        panel_trigger = 1'b0;
  logic [15:0] user_settings = 16'hA5C3;
  logic [15:0] act;
  logic        cal_active, armed, fire, pend, strobe, nvm, done, avail;
  logic        cmd_error, hv_en;
  logic [5:0]  step_number;
  logic [23:0] step_value;
  logic [7:0]  err;
  cal_status_t cal_st;
  int          error_cnt = 0;
  int          num_checks = 0;

  calibration_command_sequencer DUT (.core_clk(core_clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .device_clear(device_clear), .lock_unlocked(lock_unlocked),
    .bus_trigger(bus_trigger), .panel_trigger(panel_trigger),
    .user_settings(user_settings), .active_settings(act),
    .cal_active(cal_active), .trigger_armed(armed), .trigger_fire(fire),
    .pending_trigger(pend), .step_strobe(strobe),
    .step_number(step_number), .step_value(step_value), .nvm_write(nvm),
    .reading_done(done), .reading_available(avail),
    .cmd_error(cmd_error), .calibration_status_word(cal_st),
    .error_status_word(err), .high_voltage_range_enable(hv_en));
  cal_ctrl_model ctl (.core_clk(core_clk), .cmd(cmd),
    .cmd_valid(cmd_valid));

  // 50 MHz clock
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic t_before_entry();
    ctl.send(CMD_CAL, 6'h05, 1'b0, 24'h0);
    chk("strobe", strobe, 0);
    chk("err0", err[ERR_NOT_ENTERED], 1);
    ctl.send(CMD_STATUS, 6'h00, 1'b0, 24'h0);
    chk("err_clear", err, ERR_RESET);
    ctl.send(CMD_HV_RANGE, 6'h00, 1'b1, 24'h1);
    chk("hv_en", hv_en, 1);
  endtask

  task automatic t_enter(logic calibrated);
    ctl.send(CMD_CAL, STEP_ENTER, 1'b0, 24'h0);
    chk("active", cal_active, 1);
    chk("settings", act, CAL_SETTINGS);
    chk("armed", armed, 0);
    chk("done", done, 1);
    chk("avail", avail, 0);
    chk("status", cal_st, {6'h00, 1'b1, lock_unlocked, calibrated});
  endtask

  task automatic t_steps();
    ctl.send(CMD_CAL, 6'h02, 1'b0, 24'h0);
    chk("step2", step_number, 6'h02);
    ctl.send(CMD_CAL, 6'h03, 1'b0, 24'h0);
    chk("err4", err[ERR_NO_VALUE], 1);
    chk("step_kept", step_number, 6'h02);
    ctl.send(CMD_CAL, 6'h03, 1'b1, 24'h00ABCD);
    chk("value", step_value, 24'h00ABCD);
    ctl.send(CMD_CAL, 6'h1A, 1'b0, 24'h0);
    chk("step26", step_number, 6'h1A);
    ctl.send(CMD_DEFAULTS, 6'h00, 1'b0, 24'h0);
    chk("illegal", cmd_error, 1);
    chk("settings_kept", act, CAL_SETTINGS);
    ctl.send(CMD_CAL, 6'h3C, 1'b0, 24'h0);
    chk("err2", err[ERR_BAD_STEP], 1);
    panel_trigger = 1'b1;
    bus_trigger = 1'b1;
    tick();
    panel_trigger = 1'b0;
    bus_trigger = 1'b0;
    chk("pending", pend, 1);
    chk("fire", fire, 0);
    ctl.send(CMD_CAL, 6'h23, 1'b1, 24'h000123);
    chk("step35", step_number, 6'h23);
    ctl.send(CMD_CAL, 6'h2B, 1'b1, 24'h000456);
    chk("step43", step_number, 6'h2B);
    ctl.send(CMD_CAL, STEP_SRC_CAL, 1'b0, 24'h0);
    chk("calibrated", cal_st.calibrated, 1);
  endtask

  task automatic t_exit(logic unlocked);
    lock_unlocked = unlocked;
    ctl.send(CMD_CAL, STEP_EXIT, 1'b0, 24'h0);
    chk("nvm", nvm, unlocked);
    chk("left", cal_active, 0);
    chk("restored", act, user_settings);
    chk("pend_clear", pend, 0);
    tick();
    chk("no_sweep", fire, 0);
  endtask

  task automatic t_trigger_idle();
    bus_trigger = 1'b1;
    tick();
    chk("rearmed", armed, 1);
    chk("fire_first", fire, 0);
    tick();
    bus_trigger = 1'b0;
    chk("fire_run", fire, 1);
    tick();
    chk("fire_end", fire, 0);
  endtask

  task automatic t_hv_and_clear();
    ctl.send(CMD_HV_RANGE, 6'h00, 1'b1, 24'h0);
    chk("hv_off", hv_en, 0);
    t_enter(1'b1);
    ctl.send(CMD_CAL, 6'h1E, 1'b0, 24'h0);
    chk("err3", err[ERR_HV_DISABLED], 1);
    ctl.send(CMD_CAL, 6'h02, 1'b0, 24'h0);
    device_clear = 1'b1;
    tick();
    device_clear = 1'b0;
    chk("cleared", step_number, 6'h00);
  endtask

  // watchdog against a hang
  initial
  begin
    #200000;
    error_cnt++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    t_before_entry();
    t_enter(1'b0);
    t_steps();
    t_exit(1'b0);
    t_enter(1'b1);
    t_exit(1'b1);
    t_trigger_idle();
    t_hv_and_clear();
    final_report();
  end
endmodule
